// File: rtl/pslc_supply_status.sv
// Behaviour
// - Open protocol pin: analog or management; low pin: serial-line.
// - Serial-line mode ignores margin input, trim pot and trim switch.
// - Manual switch off hands on/off to host enable; switch defaults on.
// - Serial-line mode disregards the host enable input.
// - Serial-line mode uses its own enable input; other modes ignore it.
// - Output-good high while output delivered, low when output is off.
// - Output-good pulses at 1 ms during overload or current limit.
// - Fault low on thermal shutdown, over-voltage or internal failure.
// - Serial-line mode never drives the fault line.
// - Over-temperature drives thermal warning low 10 s before shutdown.
// - Restart when temperature recovers, releasing thermal warning.
// - Serial-line mode never drives the thermal warning line.
// - Input LED steady when input ok, blinks when out of limits.
// - Management mode: output LED on when good, blinks in overload.
// - Thermal alarm: OK LEDs on, amber on, red off, warning low.
// - Input out of limits: input LED blinks, others off, good line low.
// - Over-voltage latch or boost failure: red LED on, fault line low.
// - Non-shutdown internal failure: OK LEDs on, red on, fault low.
// - Management service request: amber blinks, status lines stay high.
// - Serial-line link lost: red LED blinks, OK LEDs on, good line high.
`timescale 1ns/1ns
`default_nettype none
module pslc_supply_status
    import pslc_pkg::*;
#(
    parameter int unsigned BLINK_CYC_P = BLINK_CYC,
    parameter int unsigned GOOD_PULSE_CYC_P = GOOD_PULSE_CYC,
    parameter int unsigned THERM_CYC_P = THERM_CYC
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Pins and switches from outside the clock domain
    input wire logic protocol_open,
    input wire logic host_enable_n,
    input wire logic serial_line_output_on,
    input wire logic onoff_switch_on,
    input wire logic trim_switch_on,
    // Internal conditions on this clock
    input wire pslc_cond_t cond,
    // Power stage control
    output logic main_on,
    output logic trim_pot_sel,
    output logic margin_sel,
    // Open-drain status lines
    output logic output_good_n_o,
    output logic output_good_n_oe,
    output logic fault_n_o,
    output logic fault_n_oe,
    output logic thermal_warn_n_o,
    output logic thermal_warn_n_oe,
    // Front panel
    output pslc_led_t leds,
    output logic serial_mode
);
    localparam int unsigned BW = $clog2(BLINK_CYC_P + 1);
    localparam int unsigned PW = $clog2(GOOD_PULSE_CYC_P + 1);
    localparam int unsigned TW = $clog2(THERM_CYC_P + 1);

    // ==========================================================
    // Pin synchroniser
    // ==========================================================
    logic [PIN_W-1:0] sync1_r;
    logic [PIN_W-1:0] sync2_r;

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            sync1_r <= PIN_RST;
            sync2_r <= PIN_RST;
        end
        else
        begin
            sync1_r <= {trim_switch_on, onoff_switch_on,
                        serial_line_output_on, host_enable_n,
                        protocol_open};
            sync2_r <= sync1_r;
        end
    end

    wire logic ser_mode = ~sync2_r[PIN_PROTO_OPEN];
    wire logic host_on = ~sync2_r[PIN_HOST_EN_N];
    wire logic ser_on = sync2_r[PIN_SER_ON];
    wire logic sw_on = sync2_r[PIN_SWITCH_ON];
    wire logic trim_on = sync2_r[PIN_TRIM_DIP];

    // ==========================================================
    // On/off source selection
    // ==========================================================
    // Serial-line mode uses only its own enable; otherwise the switch
    // wins, and the host enable counts only with the switch off.
    wire logic analog_cmd = sw_on | host_on;
    wire logic cmd_on = ser_mode ? ser_on : analog_cmd;
    wire logic standby = ~cmd_on | cond.standby_cmd;

    // ==========================================================
    // Thermal warning timer and shutdown
    // ==========================================================
    logic [TW-1:0] therm_cnt_r;
    logic [TW-1:0] therm_cnt_nxt;
    logic therm_shut_r;
    logic therm_shut_nxt;

    wire logic therm_done = therm_cnt_r == TW'(THERM_CYC_P - 1);
    assign therm_cnt_nxt = (!cond.over_temp || therm_shut_r) ? '0
                         : therm_cnt_r + TW'(1);
    assign therm_shut_nxt = cond.over_temp
                          & (therm_shut_r | therm_done);

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            therm_cnt_r <= '0;
            therm_shut_r <= 1'b0;
        end
        else
        begin
            therm_cnt_r <= therm_cnt_nxt;
            therm_shut_r <= therm_shut_nxt;
        end
    end

    // ==========================================================
    // Blink and output-good pulse generators
    // ==========================================================
    logic [BW-1:0] blink_cnt_r;
    logic blink_r;
    logic [PW-1:0] pulse_cnt_r;
    logic pulse_r;

    wire logic blink_wrap = blink_cnt_r == BW'(BLINK_CYC_P - 1);
    wire logic pulse_wrap = pulse_cnt_r == PW'(GOOD_PULSE_CYC_P - 1);

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            blink_cnt_r <= '0;
            blink_r <= 1'b0;
            pulse_cnt_r <= '0;
            pulse_r <= 1'b0;
        end
        else
        begin
            blink_cnt_r <= blink_wrap ? '0 : blink_cnt_r + BW'(1);
            blink_r <= blink_r ^ blink_wrap;
            pulse_cnt_r <= pulse_wrap ? '0 : pulse_cnt_r + PW'(1);
            pulse_r <= pulse_r ^ pulse_wrap;
        end
    end

    // ==========================================================
    // Status decode
    // ==========================================================
    wire logic hard_fail = cond.ov_latched | cond.boost_fail;
    wire logic ot_active = cond.over_temp | therm_shut_r;
    wire logic delivered = cond.input_ok & ~standby
                         & ~therm_shut_r & ~hard_fail;
    wire logic any_fault = therm_shut_r | hard_fail
                         | cond.internal_fault;
    wire logic good_low = ~delivered
                      | (cond.overload & pulse_r);
    wire logic fault_low = any_fault & ~ser_mode;
    wire logic warn_low = ot_active & ~ser_mode;
    wire logic mgmt = cond.mgmt_mode & ~ser_mode;

    wire pslc_led_t led_nxt;
    assign led_nxt.input_ok = cond.input_ok
        | (cond.input_present & blink_r);
    assign led_nxt.output_ok = delivered
        & ~(cond.overload & mgmt & ~blink_r);
    assign led_nxt.service = ot_active
        | (cond.service_req & mgmt & blink_r);
    assign led_nxt.fault = any_fault
        | (cond.comm_lost & ser_mode & blink_r);

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            main_on <= 1'b0;
            trim_pot_sel <= 1'b0;
            margin_sel <= 1'b0;
            output_good_n_o <= 1'b0;
            output_good_n_oe <= 1'b1;
            fault_n_o <= 1'b0;
            fault_n_oe <= 1'b0;
            thermal_warn_n_o <= 1'b0;
            thermal_warn_n_oe <= 1'b0;
            leds <= LED_RST;
            serial_mode <= 1'b0;
        end
        else
        begin
            main_on <= delivered;
            trim_pot_sel <= ~ser_mode & trim_on;
            margin_sel <= ~ser_mode & ~trim_on;
            output_good_n_o <= 1'b0;
            output_good_n_oe <= good_low;
            fault_n_o <= 1'b0;
            fault_n_oe <= fault_low;
            thermal_warn_n_o <= 1'b0;
            thermal_warn_n_oe <= warn_low;
            leds <= led_nxt;
            serial_mode <= ser_mode;
        end
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    a_serial_ignore_host: assert property (
        ser_mode && !ser_on && !cond.standby_cmd |=> !main_on)
        else $error("serial mode output on without serial enable");

    a_switch_off_host: assert property (
        !ser_mode && !sw_on && !host_on |=> !main_on)
        else $error("output on with switch and host enable off");

    a_serial_enable_on: assert property (
        ser_mode && ser_on && cond.input_ok && !cond.standby_cmd
        && !hard_fail && !therm_shut_r |=> main_on)
        else $error("serial enable did not turn output on");

    a_good_follows_out: assert property (
        !delivered |=> output_good_n_oe)
        else $error("output good released while output off");

    a_good_pulse_len: assert property (
        $rose(pulse_r) |-> pulse_r [*8])
        else $error("output good pulse phase too short");

    a_fault_serial: assert property (
        ser_mode |=> !fault_n_oe)
        else $error("fault line driven in serial mode");

    a_warn_serial: assert property (
        ser_mode |=> !thermal_warn_n_oe)
        else $error("thermal warning driven in serial mode");

    a_therm_delay: assert property (
        $rose(cond.over_temp) && !therm_shut_r
        |=> !therm_shut_r [*2])
        else $error("thermal shutdown without warning delay");

    a_therm_restart: assert property (
        therm_shut_r && !cond.over_temp |=> !therm_shut_r)
        else $error("no restart after temperature recovery");

    a_trim_serial: assert property (
        ser_mode |=> !trim_pot_sel && !margin_sel)
        else $error("trim path active in serial mode");

    a_standby_led: assert property (
        cond.standby_cmd |=> !leds.output_ok && output_good_n_oe)
        else $error("standby left output indication on");

    a_fault_led: assert property (
        cond.internal_fault |=> leds.fault)
        else $error("internal failure without red LED");

    a_warn_low: assert property (
        cond.over_temp && !ser_mode |=> thermal_warn_n_oe && leds.service)
        else $error("over-temperature without warning indication");

    a_shut_fault: assert property (
        therm_shut_r && !ser_mode
        |=> fault_n_oe && output_good_n_oe && !main_on)
        else $error("thermal shutdown not reported as fault");

    a_hard_fail_led: assert property (
        hard_fail |=> leds.fault && !leds.output_ok && !main_on)
        else $error("latched failure indication wrong");

    a_input_limits: assert property (
        cond.input_present && !cond.input_ok
        |=> output_good_n_oe && !leds.output_ok)
        else $error("input out of limits left output indication on");

    a_comm_blink: assert property (
        ser_mode && cond.comm_lost && !any_fault
        |=> leds.fault == $past(blink_r))
        else $error("red LED not blinking on lost link");

    a_service_blink: assert property (
        cond.service_req && mgmt && !ot_active
        |=> leds.service == $past(blink_r))
        else $error("amber LED not blinking on service request");

    a_good_pulse_out: assert property (
        delivered && cond.overload |=> output_good_n_oe == $past(pulse_r))
        else $error("output good not pulsing in overload");

    a_blink_len: assert property (
        $rose(blink_r) |-> blink_r [*8])
        else $error("blink phase too short");

    c_thermal_shut: cover property (therm_shut_r && warn_low);
    c_serial_on: cover property (ser_mode && ser_on && main_on);
    c_overload_pulse: cover property (cond.overload && $rose(pulse_r));
    c_comm_blink: cover property (ser_mode && cond.comm_lost && blink_r);
    c_host_enable: cover property (!ser_mode && !sw_on && host_on);
endmodule // pslc_supply_status
`default_nettype wire

// File: common/pslc_pkg.sv
`default_nettype none
package pslc_pkg;
    // ==========================================================
    // Timing
    // ==========================================================
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned BLINK_HALF_MS = 500;
    localparam int unsigned GOOD_PULSE_MS = 1;
    localparam int unsigned THERM_WARN_S = 10;
    localparam int unsigned BLINK_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;
    localparam int unsigned GOOD_PULSE_CYC = CLK_HZ / 1000 * GOOD_PULSE_MS;
    localparam int unsigned THERM_CYC = CLK_HZ * THERM_WARN_S;

    // ==========================================================
    // Synchronised pin vector layout and reset values
    // ==========================================================
    localparam int unsigned PIN_W = 5;
    localparam int unsigned PIN_PROTO_OPEN = 0;
    localparam int unsigned PIN_HOST_EN_N = 1;
    localparam int unsigned PIN_SER_ON = 2;
    localparam int unsigned PIN_SWITCH_ON = 3;
    localparam int unsigned PIN_TRIM_DIP = 4;
    localparam logic [4:0] PIN_RST = 5'h1b;

    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed {
        logic input_present;
        logic input_ok;
        logic overload;
        logic over_temp;
        logic ov_latched;
        logic boost_fail;
        logic internal_fault;
        logic service_req;
        logic comm_lost;
        logic standby_cmd;
        logic mgmt_mode;
    } pslc_cond_t;

    typedef struct packed {
        logic input_ok;
        logic output_ok;
        logic service;
        logic fault;
    } pslc_led_t;

    localparam pslc_led_t LED_RST = 4'h0;
endpackage
`default_nettype wire

// File: tb/pslc_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module pslc_host_model (
    // Open-drain status pins of the unit
    input wire logic good_o,
    input wire logic good_oe,
    input wire logic flt_o,
    input wire logic flt_oe,
    input wire logic warn_o,
    input wire logic warn_oe,
    // Controller intent
    input wire logic want_on,
    // Levels at the controller
    output logic host_enable_n,
    output logic good_line,
    output logic fault_line,
    output logic warn_line
);
    // Pull-ups hold released lines high; a driven line shows the pin level.
    assign good_line = good_oe ? good_o : 1'b1;
    assign fault_line = flt_oe ? flt_o : 1'b1;
    assign warn_line = warn_oe ? warn_o : 1'b1;
    assign host_enable_n = ~want_on;
endmodule // pslc_host_model
`default_nettype wire

// File: tb/tb_pslc_supply_status.sv
`timescale 1ns/1ns
`default_nettype none
module tb_pslc_supply_status;
    import pslc_pkg::*;
    // ==========================================================
    // Signals
    // ==========================================================
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic proto = 1'b1;
    logic ser_on = 1'b0;
    logic sw_on = 1'b1;
    logic want_on = 1'b0;
    logic trim = 1'b1;
    pslc_cond_t cond = 11'h601;
    logic host_en_n, main_on, trim_sel, margin_sel, ser_mode;
    logic good_o, flt_o, warn_o;
    logic good_oe, flt_oe, warn_oe, good_line, fault_line, warn_line;
    pslc_led_t leds;
    wire logic [7:0] st = {main_on, good_line, fault_line, warn_line, leds};
    int num_errors = 0;
    int checked = 0;
    always #10 mclk = ~mclk;
    pslc_supply_status #(.BLINK_CYC_P(8), .GOOD_PULSE_CYC_P(10),
        .THERM_CYC_P(20)) i_pslc_supply_status (.mclk(mclk), .srst(srst),
        .protocol_open(proto), .host_enable_n(host_en_n),
        .serial_line_output_on(ser_on), .onoff_switch_on(sw_on),
        .trim_switch_on(trim), .cond(cond), .main_on(main_on),
        .trim_pot_sel(trim_sel), .margin_sel(margin_sel),
        .output_good_n_o(good_o), .output_good_n_oe(good_oe),
        .fault_n_o(flt_o), .fault_n_oe(flt_oe),
        .thermal_warn_n_o(warn_o), .thermal_warn_n_oe(warn_oe),
        .leds(leds), .serial_mode(ser_mode));
    pslc_host_model i_pslc_host_model (.good_o(good_o), .good_oe(good_oe),
        .flt_o(flt_o), .flt_oe(flt_oe), .warn_o(warn_o), .warn_oe(warn_oe),
        .want_on(want_on), .host_enable_n(host_en_n),
        .good_line(good_line), .fault_line(fault_line),
        .warn_line(warn_line));
    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // Counts level changes of one status bit over n cycles.
    task automatic tg(input int b, input int n, input logic [7:0] exp);
        logic p;
        int c;
        c = 0;
        p = st[b];
        repeat (n)
        begin
            @(negedge mclk);
            if (st[b] !== p) c++;
            p = st[b];
        end
        chk(8'(c), exp);
    endtask
    task automatic done(input string s);
        $display("test %s done", s);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ==========================================================
    // Tests
    // ==========================================================
    initial
    begin
        cyc(12);
        chk(st, 8'h30);
        srst = 1'b0;
        cyc(4);
        chk(st, 8'hfc);
        chk({7'h0, ser_mode}, 8'h00);
        chk({6'h0, trim_sel, margin_sel}, 8'h02);
        sw_on = 1'b0;
        trim = 1'b0;
        cyc(4);
        chk(st, 8'h38);
        chk({6'h0, trim_sel, margin_sel}, 8'h01);
        want_on = 1'b1;
        cyc(4);
        chk(st, 8'hfc);
        cond.standby_cmd = 1'b1;
        cyc(2);
        chk(st, 8'h38);
        cond.standby_cmd = 1'b0;
        done("enable");
        cond.input_ok = 1'b0;
        cyc(2);
        chk(st & 8'h77, 8'h30);
        tg(3, 32, 8'h04);
        cond.input_ok = 1'b1;
        cond.internal_fault = 1'b1;
        cyc(2);
        chk(st, 8'hdd);
        cond.internal_fault = 1'b0;
        cond.ov_latched = 1'b1;
        cyc(2);
        chk(st, 8'h19);
        cond.ov_latched = 1'b0;
        cond.boost_fail = 1'b1;
        cyc(2);
        chk(st, 8'h19);
        cond.boost_fail = 1'b0;
        cond.service_req = 1'b1;
        cyc(2);
        chk(st & 8'hfd, 8'hfc);
        tg(1, 32, 8'h04);
        cond.service_req = 1'b0;
        done("faults");
        cond.overload = 1'b1;
        cyc(2);
        tg(6, 40, 8'h04);
        tg(2, 32, 8'h04);
        cond.mgmt_mode = 1'b0;
        cyc(2);
        tg(2, 32, 8'h00);
        cond.mgmt_mode = 1'b1;
        cond.overload = 1'b0;
        cond.over_temp = 1'b1;
        cyc(2);
        chk(st, 8'hee);
        cyc(25);
        chk(st, 8'h0b);
        cond.over_temp = 1'b0;
        cyc(3);
        chk(st, 8'hfc);
        done("thermal");
        proto = 1'b0;
        cyc(4);
        chk({7'h0, st[7]}, 8'h00);
        chk({5'h0, ser_mode, trim_sel, margin_sel}, 8'h04);
        ser_on = 1'b1;
        want_on = 1'b0;
        trim = 1'b1;
        cyc(4);
        chk({7'h0, st[7]}, 8'h01);
        chk({5'h0, ser_mode, trim_sel, margin_sel}, 8'h04);
        cond.over_temp = 1'b1;
        cyc(30);
        chk({6'h0, st[5:4]}, 8'h03);
        cond.over_temp = 1'b0;
        cond.comm_lost = 1'b1;
        cyc(4);
        chk(st & 8'h4e, 8'h4c);
        tg(0, 32, 8'h04);
        done("serial");
        print_verdict();
    end
    initial
    begin
        cyc(5000);
        num_errors++;
        print_verdict();
    end
endmodule // tb_pslc_supply_status
`default_nettype wire
